// File: shared/lpcd_pkg.sv
/*
  Package for the LCD power/contrast command decoder: command codes, field
  positions, reset values and power-save states shared by both ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lpcd_pkg;
  localparam logic [7:0] CMD_SCAN_BASE   = 8'h00_C0;
  localparam logic [7:0] CMD_SCAN_MASK   = 8'h00_F0;
  localparam logic [7:0] CMD_PWR_BASE    = 8'h00_28;
  localparam logic [7:0] CMD_RATIO_BASE  = 8'h00_20;
  localparam logic [7:0] CMD_GRP3_MASK   = 8'h00_F8;
  localparam logic [7:0] CMD_CONTRAST    = 8'h00_81;
  localparam logic [7:0] CMD_IND_OFF     = 8'h00_AC;
  localparam logic [7:0] CMD_IND_ON      = 8'h00_AD;
  localparam logic [7:0] CMD_DISP_OFF    = 8'h00_AE;
  localparam logic [7:0] CMD_DISP_ON     = 8'h00_AF;
  localparam logic [7:0] CMD_ALL_NORMAL  = 8'h00_A4;
  localparam logic [7:0] CMD_ALL_ON      = 8'h00_A5;
  localparam logic [7:0] CMD_SOFT_RESET  = 8'h00_E2;
  localparam int         SCAN_DIR_BIT    = 3;
  localparam int         PWR_FOLLOWER    = 0;
  localparam int         PWR_REGULATOR   = 1;
  localparam int         PWR_BOOSTER     = 2;
  localparam logic [2:0] RATIO_RESET     = 3'h0;
  localparam logic [5:0] CONTRAST_RESET  = 6'h20;
  localparam logic [5:0] CONTRAST_ADVISE = 6'h20;
  localparam logic [1:0] IND_RESET       = 2'h0;
  localparam logic [1:0] IND_OFF_STATE   = 2'h0;
  localparam logic [2:0] PWR_RESET       = 3'h0;
  // Blink half-periods at the 100 MHz clock; about 1 s and 0.5 s periods
  localparam int         CLK_HZ          = 100_000_000;
  localparam int         BLINK_SLOW_MS   = 500;
  localparam int         BLINK_FAST_MS   = 250;
  localparam int         BLINK_SLOW_CYC  = CLK_HZ / 1000 * BLINK_SLOW_MS;
  localparam int         BLINK_FAST_CYC  = CLK_HZ / 1000 * BLINK_FAST_MS;
  localparam int         POLARITY_CYC    = 1000;

  typedef enum logic [1:0] {
    PS_ACTIVE  = 2'b00,
    PS_SLEEP   = 2'b01,
    PS_STANDBY = 2'b10
  } lpcd_ps_t;

  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_CONTRAST = 2'b01,
    SEQ_IND      = 2'b10
  } lpcd_seq_t;
endpackage

// File: shared/lpcd_if.sv
/*
  Command link between the host and the decoder: one write strobe with the
  data/command select and a byte. Assumes both ends share clk and nrst.
*/
`timescale 1ns/1ps
interface lpcd_if (
  input wire logic clk,
  input wire logic nrst
);
  logic       wr_stb;
  logic       dc_sel;
  logic [7:0] data;

  modport device (input clk, input nrst, input wr_stb, input dc_sel, input data);
  modport host (input clk, input nrst, output wr_stb, output dc_sel, output data);
endinterface

// File: design/lpcd_host.sv
/*
  Host end: turns user requests into command bytes on the link, one byte
  a cycle, sending two-byte commands back to back.
  Assumes the user holds cmd_valid until cmd_ready and keeps fields stable.
*/
`timescale 1ns/1ps
module lpcd_host (
  // Link
  lpcd_if.host          lnk,
  // User request
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_has_arg,
  input  wire logic [7:0] cmd_arg,
  output logic            cmd_ready
);
  logic       second_reg;
  logic [7:0] arg_reg;
  logic       stb_reg;
  logic [7:0] data_reg;

  assign cmd_ready  = !second_reg;
  assign lnk.wr_stb = stb_reg;
  assign lnk.dc_sel = 1'b0;
  assign lnk.data   = data_reg;

  // The argument follows the opcode on the very next cycle, nothing between [RL6] [RL10]
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      second_reg <= 1'b0;
      arg_reg    <= 8'h00_00;
      stb_reg    <= 1'b0;
      data_reg   <= 8'h00_00;
    end else if (second_reg) begin
      second_reg <= 1'b0;
      stb_reg    <= 1'b1;
      data_reg   <= arg_reg;
    end else if (cmd_valid) begin
      second_reg <= cmd_has_arg;
      arg_reg    <= cmd_arg;
      stb_reg    <= 1'b1;
      data_reg   <= cmd_byte;
    end else begin
      stb_reg    <= 1'b0;
    end
  end
endmodule

// File: design/lpcd_device.sv
/*
  Device end: decodes command bytes into scan direction, power circuit,
  regulator ratio, contrast and static indicator state, and runs power save.
  Assumes the host keeps two-byte sequences unbroken on the link.
*/
// Function
// RL1: C0h-CFh bit 3 selects scan direction
// RL2: 28h-2Fh stores 3-bit power configuration
// RL3: Bits enable follower, regulator, booster
// RL4: 20h-27h stores regulator resistor ratio
// RL5: 81h arms contrast value mode
// RL6: Host sends value right after 81h
// RL7: Value loads six bits, releases mode
// RL8: Host advised contrast 100000 if unused
// RL9: ACh indicator off; ADh on, arms register
// RL10: Indicator value follows; mode then cleared
// RL11: Two bits pick off, slow, fast, on
// RL12: Indicator only changed by indicator commands
// RL13: All-on while display off enters power save
// RL14: Host wakes with display-on plus indicator-on
// RL15: Sleep stops oscillator, supplies; outputs grounded
// RL16: Standby grounds outputs, indicator keeps running
// RL17: Power save keeps settings and RAM access
// RL18: Soft reset in standby goes sleep
// RL19: E2h reinitialises ratio, contrast, indicator mode
// RL20: A5h while display off is power save
// RL21: Only command writes accepted; reset clears mode
// RL22: Pending second byte always consumed
`timescale 1ns/1ps
module lpcd_device #(
  parameter int BLINK_SLOW = lpcd_pkg::BLINK_SLOW_CYC,
  parameter int BLINK_FAST = lpcd_pkg::BLINK_FAST_CYC
) (
  // Link
  lpcd_if.device          lnk,
  // Settings
  output logic            scan_reverse,
  output logic [2:0]      power_circuit_control,
  output logic [2:0]      regulator_resistor_ratio,
  output logic [5:0]      contrast_level,
  output logic [1:0]      indicator_blink_state,
  // Supplies and drivers
  output logic            osc_run,
  output logic            follower_on,
  output logic            regulator_on,
  output logic            booster_on,
  output logic            drivers_grounded,
  output logic            display_on,
  output logic            all_on,
  output logic [1:0]      power_save_state,
  // Indicator pins
  output logic            polarity_toggle_out,
  output logic            indicator_drive_pin
);
  lpcd_pkg::lpcd_ps_t  ps_reg;
  lpcd_pkg::lpcd_seq_t seq_reg;
  logic                scan_reg;
  logic [2:0]          pwr_reg;
  logic [2:0]          ratio_reg;
  logic [5:0]          contrast_reg;
  logic [1:0]          ind_reg;
  logic                ind_on_reg;
  logic                disp_on_reg;
  logic                all_on_reg;
  logic [31:0]         blink_cnt_reg;
  logic                blink_reg;
  logic [31:0]         pol_cnt_reg;
  logic                pol_reg;
  logic                cmd;
  logic                in_seq;
  logic [7:0]          d;

  function automatic logic grp(input logic [7:0] b, input logic [7:0] mask, input logic [7:0] base);
    grp = (b & mask) == base;
  endfunction

  assign d      = lnk.data;
  assign cmd    = lnk.wr_stb && !lnk.dc_sel; // [RL21]
  assign in_seq = seq_reg != lpcd_pkg::SEQ_IDLE;

  // Two-byte sequence tracking; any command byte in a pending sequence is its value
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      seq_reg <= lpcd_pkg::SEQ_IDLE; // [RL21]
    end else if (cmd) begin
      if (in_seq) begin
        seq_reg <= lpcd_pkg::SEQ_IDLE; // [RL7] [RL10] [RL22]
      end else if (d == lpcd_pkg::CMD_CONTRAST) begin
        seq_reg <= lpcd_pkg::SEQ_CONTRAST; // [RL5]
      end else if (d == lpcd_pkg::CMD_IND_ON) begin
        seq_reg <= lpcd_pkg::SEQ_IND; // [RL9]
      end else if (d == lpcd_pkg::CMD_SOFT_RESET) begin
        seq_reg <= lpcd_pkg::SEQ_IDLE; // [RL19]
      end
    end
  end

  // Single-byte settings; power configuration is left alone by soft reset
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      scan_reg    <= 1'b0;
      pwr_reg     <= lpcd_pkg::PWR_RESET;
      ratio_reg   <= lpcd_pkg::RATIO_RESET;
      disp_on_reg <= 1'b0;
      all_on_reg  <= 1'b0;
    end else if (cmd && !in_seq) begin
      if (grp(d, lpcd_pkg::CMD_SCAN_MASK, lpcd_pkg::CMD_SCAN_BASE)) begin
        scan_reg <= d[lpcd_pkg::SCAN_DIR_BIT]; // [RL1]
      end else if (grp(d, lpcd_pkg::CMD_GRP3_MASK, lpcd_pkg::CMD_PWR_BASE)) begin
        pwr_reg <= d[2:0]; // [RL2]
      end else if (grp(d, lpcd_pkg::CMD_GRP3_MASK, lpcd_pkg::CMD_RATIO_BASE)) begin
        ratio_reg <= d[2:0]; // [RL4]
      end else if (d == lpcd_pkg::CMD_SOFT_RESET) begin
        ratio_reg <= lpcd_pkg::RATIO_RESET; // [RL19]
      end else if (d == lpcd_pkg::CMD_DISP_ON) begin
        disp_on_reg <= 1'b1;
      end else if (d == lpcd_pkg::CMD_DISP_OFF) begin
        disp_on_reg <= 1'b0;
      end else if (d == lpcd_pkg::CMD_ALL_ON) begin
        all_on_reg <= 1'b1;
      end else if (d == lpcd_pkg::CMD_ALL_NORMAL) begin
        all_on_reg <= 1'b0;
      end
    end
  end

  // Contrast register
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      contrast_reg <= lpcd_pkg::CONTRAST_RESET;
    end else if (cmd && seq_reg == lpcd_pkg::SEQ_CONTRAST) begin
      contrast_reg <= d[5:0]; // [RL7] [RL22]
    end else if (cmd && !in_seq && d == lpcd_pkg::CMD_SOFT_RESET) begin
      contrast_reg <= lpcd_pkg::CONTRAST_RESET; // [RL19]
    end
  end

  // Static indicator: only the indicator commands and reset touch it
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      ind_on_reg <= 1'b0;
      ind_reg    <= lpcd_pkg::IND_RESET;
    end else if (cmd && seq_reg == lpcd_pkg::SEQ_IND) begin
      ind_reg <= d[1:0]; // [RL10] [RL11] [RL22]
    end else if (cmd && !in_seq) begin
      if (d == lpcd_pkg::CMD_IND_OFF) begin
        ind_on_reg <= 1'b0; // [RL9] [RL12]
      end else if (d == lpcd_pkg::CMD_IND_ON) begin
        ind_on_reg <= 1'b1; // [RL9]
      end else if (d == lpcd_pkg::CMD_SOFT_RESET) begin
        ind_on_reg <= 1'b0; // [RL19]
        ind_reg    <= lpcd_pkg::IND_RESET;
      end
    end
  end

  // Power save; settings registers are not touched on entry or exit [RL17]
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      ps_reg <= lpcd_pkg::PS_ACTIVE;
    end else if (cmd && !in_seq) begin
      unique case (ps_reg)
        lpcd_pkg::PS_ACTIVE: begin
          if (d == lpcd_pkg::CMD_ALL_ON && !disp_on_reg) begin
            ps_reg <= ind_on_reg ? lpcd_pkg::PS_STANDBY : lpcd_pkg::PS_SLEEP; // [RL13] [RL20]
          end
        end
        lpcd_pkg::PS_SLEEP: begin
          // Release needs display-on or all-on off; indicator-on is the host's part [RL14]
          if (d == lpcd_pkg::CMD_DISP_ON || d == lpcd_pkg::CMD_ALL_NORMAL) begin
            ps_reg <= lpcd_pkg::PS_ACTIVE;
          end
        end
        lpcd_pkg::PS_STANDBY: begin
          if (d == lpcd_pkg::CMD_SOFT_RESET) begin
            ps_reg <= lpcd_pkg::PS_SLEEP; // [RL18]
          end else if (d == lpcd_pkg::CMD_DISP_ON || d == lpcd_pkg::CMD_ALL_NORMAL) begin
            ps_reg <= lpcd_pkg::PS_ACTIVE;
          end
        end
        default: ps_reg <= lpcd_pkg::PS_ACTIVE;
      endcase
    end
  end

  // Blink timebase; halts with the oscillator in sleep
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else if (ps_reg != lpcd_pkg::PS_SLEEP) begin
      if (blink_cnt_reg >= 32'(((ind_reg == 2'h1) ? BLINK_SLOW : BLINK_FAST) - 1)) begin
        blink_cnt_reg <= 32'h0000_0000;
        blink_reg     <= !blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Frame polarity toggles; indicator pin is opposite it when lit, follows it when dark
  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      pol_cnt_reg <= 32'h0000_0000;
      pol_reg     <= 1'b0;
    end else if (ps_reg != lpcd_pkg::PS_SLEEP) begin
      if (pol_cnt_reg >= 32'(lpcd_pkg::POLARITY_CYC - 1)) begin
        pol_cnt_reg <= 32'h0000_0000;
        pol_reg     <= !pol_reg;
      end else begin
        pol_cnt_reg <= pol_cnt_reg + 32'h0000_0001;
      end
    end
  end

  logic lit;
  always_comb begin
    unique case (ind_reg)
      2'h0:    lit = 1'b0;
      2'h1:    lit = blink_reg;
      2'h2:    lit = blink_reg;
      default: lit = 1'b1;
    endcase
    lit = lit && ind_on_reg;
  end

  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      polarity_toggle_out <= 1'b0;
      indicator_drive_pin <= 1'b0;
    end else if (ps_reg == lpcd_pkg::PS_SLEEP) begin
      polarity_toggle_out <= 1'b0; // [RL15]
      indicator_drive_pin <= 1'b0;
    end else begin
      polarity_toggle_out <= pol_reg; // [RL12] [RL16]
      indicator_drive_pin <= lit ? !pol_reg : pol_reg;
    end
  end

  assign scan_reverse             = scan_reg;
  assign power_circuit_control    = pwr_reg;
  assign regulator_resistor_ratio = ratio_reg;
  assign contrast_level           = contrast_reg;
  assign indicator_blink_state    = ind_reg;
  assign display_on               = disp_on_reg;
  assign all_on                   = all_on_reg;
  assign power_save_state         = ps_reg;
  assign osc_run                  = ps_reg != lpcd_pkg::PS_SLEEP; // [RL15]
  assign drivers_grounded         = ps_reg != lpcd_pkg::PS_ACTIVE; // [RL15] [RL16]
  assign follower_on  = pwr_reg[lpcd_pkg::PWR_FOLLOWER] && ps_reg == lpcd_pkg::PS_ACTIVE; // [RL3]
  assign regulator_on = pwr_reg[lpcd_pkg::PWR_REGULATOR] && ps_reg == lpcd_pkg::PS_ACTIVE; // [RL3]
  assign booster_on   = pwr_reg[lpcd_pkg::PWR_BOOSTER] && ps_reg == lpcd_pkg::PS_ACTIVE; // [RL3]
endmodule

// File: verification/lpcd_link_chk.sv
/*
  Checker for the command link between host and decoder ends.
  Assumes it is instantiated beside the link interface, fed its plain signals.
*/
`timescale 1ns/1ps
module lpcd_link_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Link
  input wire logic       wr_stb,
  input wire logic       dc_sel,
  input wire logic [7:0] data,
  // Decoder state under watch
  input wire logic [5:0] contrast_level,
  input wire logic [1:0] power_save_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic pend_reg;
  logic con_reg;
  logic took;

  assign took = wr_stb && !dc_sel;

  // A value byte that happens to equal an opcode must not re-arm the pair
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_reg <= 1'b0;
      con_reg  <= 1'b0;
    end else if (took) begin
      pend_reg <= !pend_reg && (data == lpcd_pkg::CMD_CONTRAST || data == lpcd_pkg::CMD_IND_ON);
      con_reg  <= !pend_reg && data == lpcd_pkg::CMD_CONTRAST;
    end
  end

  property p_sel_cmd;
    wr_stb |-> !dc_sel;
  endproperty
  a_sel_cmd: assert property (p_sel_cmd) else $error("link byte sent with data select high");

  property p_rst_quiet;
    $rose(nrst) |-> !wr_stb;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("strobe on first edge after reset");

  property p_contrast_next;
    took && !pend_reg && data == lpcd_pkg::CMD_CONTRAST |=> took;
  endproperty
  a_contrast_next: assert property (p_contrast_next) else $error("contrast value not back to back");

  property p_ind_next;
    took && !pend_reg && data == lpcd_pkg::CMD_IND_ON |=> took;
  endproperty
  a_ind_next: assert property (p_ind_next) else $error("indicator value not back to back");

  // The decoder must load the low six bits of the value byte, whatever the upper bits
  property p_pair_closed;
    took && con_reg |=> contrast_level == $past(data[5:0]);
  endproperty
  a_pair_closed: assert property (p_pair_closed) else $error("contrast not loaded from value byte");

  property p_reset_sleep;
    took && !pend_reg && data == lpcd_pkg::CMD_SOFT_RESET && power_save_state == lpcd_pkg::PS_STANDBY
      |=> power_save_state == lpcd_pkg::PS_SLEEP;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep) else $error("soft reset in standby did not sleep");

  c_pair: cover property (took && pend_reg);
endmodule

// File: verification/lcd_power_contrast_cmd_decoder_bench.sv
/*
  Bench joining host and decoder ends, plus a second decoder on a link driven
  directly so that malformed traffic can be sent. Assumes 100 MHz clock.
*/
`timescale 1ns/1ps
module lcd_power_contrast_cmd_decoder_bench;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic       cmd_has_arg = 1'b0;
  logic [7:0] cmd_arg = 8'h00;
  logic       cmd_ready;
  logic       rdy_s;
  logic       scan_rev, osc_run, fol, reg_on, boost, grounded, disp_on, all_on, pol, ind_pin;
  logic [2:0] pcc, ratio, pcc_b, ratio_b;
  logic [5:0] contrast, contrast_b;
  logic [1:0] ind, ps, ind_b;
  int         fail_count = 0;
  int         samples_checked = 0;

  always #5 clk = ~clk;
  // Ready is combinational; sample it away from the edge that takes requests
  always @(negedge clk) rdy_s = cmd_ready;

  lpcd_if lnk (.clk(clk), .nrst(nrst));
  lpcd_if lnk_b (.clk(clk), .nrst(nrst));
  initial begin
    lnk_b.wr_stb = 1'b0;
    lnk_b.dc_sel = 1'b0;
    lnk_b.data = 8'h00;
  end

  lpcd_host u_lpcd_host (.lnk(lnk.host), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready));
  lpcd_device #(.BLINK_SLOW(8), .BLINK_FAST(4)) u_lpcd_device (.lnk(lnk.device), .scan_reverse(scan_rev),
    .power_circuit_control(pcc), .regulator_resistor_ratio(ratio), .contrast_level(contrast),
    .indicator_blink_state(ind), .osc_run(osc_run), .follower_on(fol), .regulator_on(reg_on),
    .booster_on(boost), .drivers_grounded(grounded), .display_on(disp_on), .all_on(all_on),
    .power_save_state(ps), .polarity_toggle_out(pol), .indicator_drive_pin(ind_pin));
  lpcd_device #(.BLINK_SLOW(8), .BLINK_FAST(4)) u_lpcd_device_b (.lnk(lnk_b.device), .scan_reverse(),
    .power_circuit_control(pcc_b), .regulator_resistor_ratio(ratio_b), .contrast_level(contrast_b),
    .indicator_blink_state(ind_b), .osc_run(), .follower_on(), .regulator_on(), .booster_on(),
    .drivers_grounded(), .display_on(), .all_on(), .power_save_state(), .polarity_toggle_out(),
    .indicator_drive_pin());
  lpcd_link_chk u_chk (.clk(clk), .nrst(nrst), .wr_stb(lnk.wr_stb), .dc_sel(lnk.dc_sel), .data(lnk.data),
    .contrast_level(contrast), .power_save_state(ps));

  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request through the host end; effects are settled three edges after it is taken
  task automatic send(input logic [7:0] b, input logic has, input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    cmd_has_arg <= has;
    cmd_arg <= a;
    do begin
      @(posedge clk);
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // One raw byte on the second link; the idle data shows the inverse, not a stale copy
  task automatic raw(input logic dc, input logic [7:0] b);
    @(posedge clk);
    lnk_b.wr_stb <= 1'b1;
    lnk_b.dc_sel <= dc;
    lnk_b.data <= b;
    @(posedge clk);
    lnk_b.wr_stb <= 1'b0;
    lnk_b.data <= ~b;
    @(negedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(contrast, 8'h20); chk(ratio, 8'h00); chk(ps, 8'h00); chk(osc_run, 8'h01);
    for (int i = 0; i < 16; i++) begin
      send(lpcd_pkg::CMD_SCAN_BASE | 8'(i), 1'b0, 8'h00);
      chk(scan_rev, i[3]);
    end
    for (int i = 0; i < 8; i++) begin
      send(lpcd_pkg::CMD_PWR_BASE | 8'(i), 1'b0, 8'h00);
      chk(pcc, 8'(i));
      chk({boost, reg_on, fol}, 8'(i));
      send(lpcd_pkg::CMD_RATIO_BASE | 8'(i), 1'b0, 8'h00);
      chk(ratio, 8'(i));
    end
    send(8'h81, 1'b1, 8'hFF); chk(contrast, 8'h3F);
    send(8'h81, 1'b1, 8'h40); chk(contrast, 8'h00);
    send(8'h81, 1'b1, 8'h20); chk(contrast, 8'h20);
    send(8'h81, 1'b1, 8'hC0); chk(contrast, 8'h00); chk(scan_rev, 8'h01);
    send(8'h81, 1'b1, 8'h5A); chk(contrast, 8'h1A);
    for (int i = 0; i < 4; i++) begin
      send(8'hAD, 1'b1, 8'hFC | 8'(i));
      chk(ind, 8'(i));
    end
    send(8'hAE, 1'b0, 8'h00); chk(ind, 8'h03); chk(disp_on, 8'h00);
    send(8'hA5, 1'b0, 8'h00); chk(ps, 8'h02); chk(grounded, 8'h01); chk(osc_run, 8'h01);
    chk(fol, 8'h00); chk(ind_pin ^ pol, 8'h01);
    chk(pcc, 8'h07); chk(ratio, 8'h07); chk(contrast, 8'h1A);
    send(8'hE2, 1'b0, 8'h00); chk(ps, 8'h01); chk(osc_run, 8'h00);
    chk({pol, ind_pin, grounded}, 8'h01); chk(boost, 8'h00);
    chk(ratio, 8'h00); chk(contrast, 8'h20); chk(ind, 8'h00); chk(pcc, 8'h07);
    send(8'hAF, 1'b0, 8'h00); chk(ps, 8'h00); chk(grounded, 8'h00); chk(fol, 8'h01);
    send(8'hAC, 1'b0, 8'h00);
    send(8'hAE, 1'b0, 8'h00);
    send(8'hA5, 1'b0, 8'h00); chk(ps, 8'h01);
    send(8'hA4, 1'b0, 8'h00); chk(ps, 8'h00);
    send(8'hAF, 1'b0, 8'h00);
    send(8'hA5, 1'b0, 8'h00); chk(all_on, 8'h01); chk(ps, 8'h00);
    send(8'hA4, 1'b0, 8'h00); chk(all_on, 8'h00);
    raw(1'b1, 8'h2F); chk(pcc_b, 8'h00);
    raw(1'b0, 8'h81);
    raw(1'b0, 8'hAC); chk(contrast_b, 8'h2C);
    raw(1'b0, 8'hAD);
    raw(1'b0, 8'h81); chk(ind_b, 8'h01); chk(contrast_b, 8'h2C);
    raw(1'b0, 8'h27); chk(ratio_b, 8'h07);
    raw(1'b0, 8'h81);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    raw(1'b0, 8'h25); chk(ratio_b, 8'h05); chk(contrast_b, 8'h20);
    end_sim();
  end
endmodule
